// ---- pssc_defines.vh ----
`ifndef PSSC_DEFINES_VH
`define PSSC_DEFINES_VH

// Station map geometry
`define PSSC_MAP_W          128
`define PSSC_LAST_NODE      126
`define PSSC_SIG_W          16
`define PSSC_CTRL_BYTE_W    8

// Reset values
`define PSSC_ENABLE_RST     128'h0
`define PSSC_SIG_RST        16'h0000

// Data exchange watchdog: one tick period, a station that misses three ticks drops out
`define PSSC_CLK_MHZ        100
`define PSSC_DX_TICK_US     1000
`define PSSC_DX_TICK_CYC    (`PSSC_DX_TICK_US * `PSSC_CLK_MHZ)
`define PSSC_TICK_CNT_W     17
`define PSSC_AGE_W          2
`define PSSC_AGE_LIMIT      2'h2

`endif

// ---- pssc_station_cell.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pssc_defines.vh"

module pssc_station_cell (
  input  wire sys_clk,
  input  wire rst_n,
  input  wire station_active,
  input  wire dx_tick,
  input  wire dx_cycle,
  input  wire alarm_raise,
  input  wire alarm_unload,
  input  wire diag_raise,
  input  wire diag_unload,
  output reg  live_r,
  output reg  exchange_r,
  output reg  alarm_r,
  output reg  diag_r
);

  reg [`PSSC_AGE_W-1:0] age_r;

  // ==========================================================
  // Per-station state
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_r     <= 1'b0;
      exchange_r <= 1'b0;
      alarm_r    <= 1'b0;
      diag_r     <= 1'b0;
      age_r      <= {`PSSC_AGE_W{1'b0}};
    end else if (!station_active) begin
      live_r     <= 1'b0;
      exchange_r <= 1'b0;
      alarm_r    <= 1'b0;
      diag_r     <= 1'b0;
      age_r      <= {`PSSC_AGE_W{1'b0}};
    end else begin
      live_r <= 1'b1;  // see R03
      if (dx_cycle) begin
        exchange_r <= 1'b1;  // see R04
        age_r      <= {`PSSC_AGE_W{1'b0}};
      end else if (dx_tick) begin
        if (age_r == `PSSC_AGE_LIMIT)
          exchange_r <= 1'b0;  // see R04
        else
          age_r <= age_r + 2'h1;
      end
      // Raise wins over an unload in the same cycle
      if (alarm_raise)
        alarm_r <= 1'b1;  // see R05
      else if (alarm_unload)
        alarm_r <= 1'b0;  // see R05
      if (diag_raise)
        diag_r <= 1'b1;  // see R06
      else if (diag_unload)
        diag_r <= 1'b0;  // see R06
    end
  end

endmodule // pssc_station_cell
`default_nettype wire

// ---- pssc_top.v ----
// Function
// R01: Slave-mode flag reads 1 while emulating slave stations, else 0.
// R02: Signature of the configuration being executed is readable by host.
// R03: Live bitmap bit per node 0..126, 1 when node is online.
// R04: Exchange bitmap bit is 1 only while node online and exchanging cyclic data.
// R05: Alarm-waiting bit is 1 while node holds an alarm not yet unloaded.
// R06: Diagnostics-waiting bit is 1 while node holds diagnostics not yet unloaded.
// R07: Host writes enable bitmap; exchange only for configured and enabled nodes.
// R08: Host sets the enable bit for each configured station meant to run.
// R09: Once enabled, station becomes present and answers the DP master.
// R10: Master-control byte is ignored in slave operation.
// R11: Error flag is 1 when any active station is offline or not exchanging.
// R12: Positions above node 126 read 0; enable writes there have no effect.
`timescale 1ns/1ps
`default_nettype none
`include "pssc_defines.vh"

module pssc_top #(
  parameter integer DX_TICK_CYC = `PSSC_DX_TICK_CYC
) (
  input  wire                          sys_clk,
  input  wire                          rst_n,
  input  wire                          ctrl_wr,
  input  wire [`PSSC_CTRL_BYTE_W-1:0]  master_control_byte,
  input  wire [`PSSC_CTRL_BYTE_W-1:0]  redundancy_control_byte,
  input  wire [`PSSC_MAP_W-1:0]        station_enable_wdata,
  input  wire                          cfg_slave_mode,
  input  wire [`PSSC_SIG_W-1:0]        cfg_signature,
  input  wire [`PSSC_MAP_W-1:0]        cfg_station_configured,
  input  wire [`PSSC_MAP_W-1:0]        fb_dx_cycle,
  input  wire [`PSSC_MAP_W-1:0]        fb_alarm_raise,
  input  wire [`PSSC_MAP_W-1:0]        fb_alarm_unload,
  input  wire [`PSSC_MAP_W-1:0]        fb_diag_raise,
  input  wire [`PSSC_MAP_W-1:0]        fb_diag_unload,
  output reg  [`PSSC_MAP_W-1:0]        station_enable_bitmap,
  output reg  [`PSSC_MAP_W-1:0]        station_present_bitmap,
  output reg                           emulated_slave_flag,
  output reg  [`PSSC_SIG_W-1:0]        config_signature,
  output wire [`PSSC_MAP_W-1:0]        live_station_bitmap,
  output wire [`PSSC_MAP_W-1:0]        exchange_active_bitmap,
  output wire [`PSSC_MAP_W-1:0]        alarm_waiting_bitmap,
  output wire [`PSSC_MAP_W-1:0]        diag_waiting_bitmap,
  output reg                           station_comm_error_flag
);

  // Mask of valid node positions 0..126
  localparam [`PSSC_MAP_W-1:0] NODE_MASK = {1'b0, {(`PSSC_MAP_W-1){1'b1}}};

  reg  [`PSSC_TICK_CNT_W-1:0] tick_cnt_r;
  reg                         dx_tick_r;
  wire [`PSSC_MAP_W-1:0]      active_nxt;
  wire [`PSSC_MAP_W-1:0]      problem_nxt;

  // ==========================================================
  // Host control structure
  // The master-control and redundancy bytes are accepted with the structure
  // and deliberately not acted upon while emulating slaves.  // see R10
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      station_enable_bitmap <= `PSSC_ENABLE_RST;
    else if (ctrl_wr)
      station_enable_bitmap <= station_enable_wdata & NODE_MASK;  // see R07 see R12
  end

  // ==========================================================
  // Configuration status
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      emulated_slave_flag <= 1'b0;
      config_signature    <= `PSSC_SIG_RST;
    end else begin
      emulated_slave_flag <= cfg_slave_mode;  // see R01
      config_signature    <= cfg_signature;   // see R02
    end
  end

  // ==========================================================
  // Station presence towards the fieldbus engine
  assign active_nxt = {`PSSC_MAP_W{cfg_slave_mode}} & cfg_station_configured
                      & station_enable_bitmap & NODE_MASK;  // see R07 see R08

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      station_present_bitmap <= {`PSSC_MAP_W{1'b0}};
    else
      station_present_bitmap <= active_nxt;  // see R09
  end

  // ==========================================================
  // Data exchange watchdog tick
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= {`PSSC_TICK_CNT_W{1'b0}};
      dx_tick_r  <= 1'b0;
    end else if (tick_cnt_r == DX_TICK_CYC[`PSSC_TICK_CNT_W-1:0] - 17'h1) begin
      tick_cnt_r <= {`PSSC_TICK_CNT_W{1'b0}};
      dx_tick_r  <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h1;
      dx_tick_r  <= 1'b0;
    end
  end

  // ==========================================================
  // Per-station status cells
  genvar g;
  generate
    for (g = 0; g <= `PSSC_LAST_NODE; g = g + 1) begin : g_node
      pssc_station_cell u_cell (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .station_active (station_present_bitmap[g]),
        .dx_tick        (dx_tick_r),
        .dx_cycle       (fb_dx_cycle[g]),
        .alarm_raise    (fb_alarm_raise[g]),
        .alarm_unload   (fb_alarm_unload[g]),
        .diag_raise     (fb_diag_raise[g]),
        .diag_unload    (fb_diag_unload[g]),
        .live_r         (live_station_bitmap[g]),
        .exchange_r     (exchange_active_bitmap[g]),
        .alarm_r        (alarm_waiting_bitmap[g]),
        .diag_r         (diag_waiting_bitmap[g])
      );
    end
  endgenerate

  // Position 127 has no station behind it
  assign live_station_bitmap[`PSSC_MAP_W-1]    = 1'b0;  // see R12
  assign exchange_active_bitmap[`PSSC_MAP_W-1] = 1'b0;  // see R12
  assign alarm_waiting_bitmap[`PSSC_MAP_W-1]   = 1'b0;  // see R12
  assign diag_waiting_bitmap[`PSSC_MAP_W-1]    = 1'b0;  // see R12

  // ==========================================================
  // Summary error flag
  assign problem_nxt = station_present_bitmap
                       & ~(live_station_bitmap & exchange_active_bitmap);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      station_comm_error_flag <= 1'b0;
    else
      station_comm_error_flag <= |problem_nxt;  // see R11
  end

endmodule // pssc_top
`default_nettype wire

// ---- pssc_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module pssc_top_asserts #(parameter integer DX_TICK_CYC = 8) (
  input wire logic         sys_clk,
  input wire logic         rst_n,
  input wire logic         ctrl_wr,
  input wire logic         cfg_slave_mode,
  input wire logic         emulated_slave_flag,
  input wire logic         station_comm_error_flag,
  input wire logic [127:0] station_enable_wdata,
  input wire logic [127:0] cfg_station_configured,
  input wire logic [127:0] fb_alarm_raise,
  input wire logic [127:0] station_enable_bitmap,
  input wire logic [127:0] station_present_bitmap,
  input wire logic [127:0] live_station_bitmap,
  input wire logic [127:0] exchange_active_bitmap,
  input wire logic [127:0] alarm_waiting_bitmap
);
  // ==========
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_mode_flag: assert property (
    $past(rst_n) |-> emulated_slave_flag == $past(cfg_slave_mode)) else $error("mode flag");
  a_enable_write: assert property (
    ctrl_wr |=> station_enable_bitmap == {1'b0, $past(station_enable_wdata[126:0])})
    else $error("enable");
  a_top_zero: assert property (
    !(station_enable_bitmap[127] | live_station_bitmap[127])) else $error("bit 127");
  a_present_rule: assert property (
    $past(rst_n) |-> station_present_bitmap == $past({128{cfg_slave_mode}}
    & cfg_station_configured & station_enable_bitmap)) else $error("present");
  a_live_present: assert property (
    (live_station_bitmap & ~$past(station_present_bitmap)) == 128'h0) else $error("live");
  a_exch_live: assert property (
    (exchange_active_bitmap & ~live_station_bitmap) == 128'h0) else $error("exchange");
  a_alarm_set: assert property (
    |(fb_alarm_raise & station_present_bitmap) |=> (~alarm_waiting_bitmap
    & $past(fb_alarm_raise & station_present_bitmap)) == 128'h0) else $error("alarm");
  a_err_raise: assert property (
    |(live_station_bitmap & ~exchange_active_bitmap & station_present_bitmap)
    |=> station_comm_error_flag) else $error("error flag");
  c_write: cover property (ctrl_wr);
  c_exch: cover property ($rose(exchange_active_bitmap[2]));
  c_err: cover property ($rose(station_comm_error_flag));
endmodule // pssc_top_asserts
bind pssc_top pssc_top_asserts #(.DX_TICK_CYC(DX_TICK_CYC)) pssc_top_asserts_i (.*);
`default_nettype wire

// ---- pssc_dp_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module pssc_dp_master (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         poll_en,
  input  wire logic [127:0] station_present_bitmap,
  output var  logic [127:0] fb_dx_cycle
);
  logic slot_r;
  // ==========
  // Polls present stations every other cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_r <= 1'b0;
      fb_dx_cycle <= 128'h0;
    end else begin
      slot_r <= ~slot_r;
      fb_dx_cycle <= (poll_en && slot_r) ? station_present_bitmap : 128'h0;
    end
  end
endmodule // pssc_dp_master
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [127:0] wd, cf, en; logic sm;} pssc_row_t;
  logic sys_clk = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, poll_en = 1'b0, cfg_slave_mode = 1'b1;
  logic [7:0] master_control_byte = 8'h00, redundancy_control_byte = 8'h00;
  logic [15:0] cfg_signature = 16'h5a3c, config_signature;
  logic [127:0] station_enable_wdata = 128'h0, cfg_station_configured = 128'h0, fb_dx_cycle;
  logic [127:0] fb_alarm_raise = 128'h0, fb_alarm_unload = 128'h0;
  logic [127:0] fb_diag_raise = 128'h0, fb_diag_unload = 128'h0;
  logic [127:0] station_enable_bitmap, station_present_bitmap, live_station_bitmap;
  logic [127:0] exchange_active_bitmap, alarm_waiting_bitmap, diag_waiting_bitmap;
  logic emulated_slave_flag, station_comm_error_flag;
  int errors = 0, checked = 0;
  pssc_row_t rows [4] = '{'{128'h4, ~128'h0, 128'h4, 1'b1},
    '{128'hc0000000000000000000000000000001, ~128'h0, 128'h40000000000000000000000000000001, 1'b1},
    '{128'h20, 128'h4, 128'h20, 1'b1}, '{128'h4, ~128'h0, 128'h4, 1'b0}};
  pssc_top #(.DX_TICK_CYC(8)) pssc_top_i (.*);
  pssc_dp_master pssc_dp_master_i (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [127:0] d);
    station_enable_wdata = d;
    ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
    cyc(2);
  endtask
  task automatic wait_ex(input logic v);
    for (int k = 0; exchange_active_bitmap[2] !== v; k++) begin
      if (k == 200) begin
        errors++;
        report_and_stop();
      end
      cyc(1);
    end
  endtask
  // Event pulse on node 2, then compare alarm and diag bits of nodes 2..3
  task automatic ev(input logic [3:0] s, input logic [3:0] e);
    {fb_alarm_raise[2], fb_alarm_unload[2], fb_diag_raise[2], fb_diag_unload[2]} = s;
    cyc(1);
    {fb_alarm_raise[2], fb_alarm_unload[2], fb_diag_raise[2], fb_diag_unload[2]} = 4'h0;
    cyc(1);
    chk(128'({alarm_waiting_bitmap[3:2], diag_waiting_bitmap[3:2]}), 128'({e}));
  endtask
  // ==========
  // Stimulus
  initial begin
    cyc(20);
    chk(station_enable_bitmap | station_present_bitmap | live_station_bitmap, 128'h0);
    chk(128'({emulated_slave_flag, config_signature}), 128'h0);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      cfg_station_configured = rows[i].cf;
      cfg_slave_mode = rows[i].sm;
      master_control_byte = 8'(i * 85);
      redundancy_control_byte = 8'(i * 51);
      wr(rows[i].wd);
      chk(station_enable_bitmap, rows[i].en);
      chk(station_present_bitmap, rows[i].sm ? rows[i].en & rows[i].cf : 128'h0);
      chk(128'(emulated_slave_flag), 128'(rows[i].sm));
    end
    cfg_slave_mode = 1'b1;
    cfg_station_configured = ~128'h0;
    poll_en = 1'b1;
    wr(128'h4);
    wait_ex(1'b1);
    chk(live_station_bitmap, 128'h4);
    cyc(2);
    chk(128'({station_comm_error_flag, config_signature}), 128'h5a3c);
    ev(4'h8, 4'h4);
    ev(4'hc, 4'h4);
    ev(4'h4, 4'h0);
    ev(4'h2, 4'h1);
    ev(4'h1, 4'h0);
    ev(4'h3, 4'h1);
    poll_en = 1'b0;
    wait_ex(1'b0);
    cyc(1);
    chk(128'({station_comm_error_flag, live_station_bitmap[2]}), 128'h3);
    ev(4'h8, 4'h5);
    // Mid-run reset with a live station holding alarm and diagnostics
    rst_n = 1'b0;
    cyc(1);
    chk(station_enable_bitmap | station_present_bitmap | live_station_bitmap, 128'h0);
    chk(alarm_waiting_bitmap | diag_waiting_bitmap | exchange_active_bitmap, 128'h0);
    chk(128'({station_comm_error_flag, emulated_slave_flag, config_signature}), 128'h0);
    rst_n = 1'b1;
    wr(128'h0);
    cyc(1);
    chk(live_station_bitmap | station_present_bitmap, 128'h0);
    chk(128'(emulated_slave_flag), 128'h1);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
